// ===== core/splice_port.v
`timescale 1ns/1ps
`include "splice_port_defines.vh"
module splice_port (
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire option_present_i,
  input wire ctl_serial_in_i,
  input wire own_uart_tx_clk_i,
  input wire own_uart_rx_clk_i,
  input wire set_ready_i,
  input wire clear_to_send_i,
  input wire carrier_i,
  input wire ctl_secondary_carrier_i,
  input wire ring_i,
  input wire [`DIV_W-1:0] tx_half_div_i,
  input wire [`DIV_W-1:0] rx_half_div_i,
  input wire char_7bit_i,
  input wire parity_en_i,
  input wire parity_odd_i,
  input wire terminal_reset_i,
  input wire req_to_send_i,
  input wire term_ready_i,
  input wire secondary_req_i,
  input wire [7:0] tx_data_i,
  input wire tx_valid_i,
  output wire tx_ready_o,
  output wire [7:0] rx_data_o,
  output wire rx_valid_o,
  input wire rx_ready_i,
  output wire rx_error_o,
  output wire tx_stopped_o,
  output wire ctl_serial_out_o,
  output wire ctl_tx_baud_clk_o,
  output wire ctl_rx_baud_clk_o,
  output wire local_link_clk_o,
  output wire controller_reset_notice_o,
  output wire ctl_request_to_send_o,
  output wire ctl_terminal_ready_o,
  output wire ctl_secondary_request_o,
  output wire option_fitted_o,
  output wire set_ready_o,
  output wire clear_to_send_o,
  output wire carrier_o,
  output wire ctl_secondary_carrier_o,
  output wire ring_o
);

  localparam [31:0] LOCAL_HALF = `LOCAL_HALF_CYC;
  localparam [31:0] NOTICE_LEN = `NOTICE_CYC;
  localparam [`PIN_N-1:0] PIN_RST = `PIN_IDLE;

  // Pin synchronisers: three stages, accept once stages two and three agree
  wire [`PIN_N-1:0] pins_raw = {ring_i, ctl_secondary_carrier_i, carrier_i, clear_to_send_i,
    set_ready_i, own_uart_rx_clk_i, own_uart_tx_clk_i, ctl_serial_in_i, option_present_i};
  reg [`PIN_N-1:0] s1_q, s2_q, s3_q, pin_q, pin_prev_q;
  genvar g;
  generate
    for (g = 0; g < `PIN_N; g = g + 1) begin : g_sync
      always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          s1_q[g] <= PIN_RST[g];
          s2_q[g] <= PIN_RST[g];
          s3_q[g] <= PIN_RST[g];
          pin_q[g] <= PIN_RST[g];
          pin_prev_q[g] <= PIN_RST[g];
        end else begin
          s1_q[g] <= pins_raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            pin_q[g] <= s3_q[g];
          end
          pin_prev_q[g] <= pin_q[g];
        end
      end
    end
  endgenerate

  wire fitted = pin_q[`PIN_PRESENT];
  wire rxd = pin_q[`PIN_SERIAL_IN];
  wire n7 = ~fitted & char_7bit_i;
  wire par_en = ~fitted & parity_en_i;

  // Baud dividers: 0 = transmit, 1 = receive, 2 = local link
  wire [3*`DIV_W-1:0] div_half = {LOCAL_HALF[`DIV_W-1:0], rx_half_div_i, tx_half_div_i};
  reg [2:0] bclk_q;
  wire [2:0] brise;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_div
      reg [`DIV_W-1:0] cnt_q;
      wire wrap = (cnt_q + 12'h001 >= div_half[g*`DIV_W +: `DIV_W]);
      assign brise[g] = wrap & ~bclk_q[g];
      always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          cnt_q <= 12'h000;
          bclk_q[g] <= 1'b0;
        end else if (wrap) begin
          cnt_q <= 12'h000;
          bclk_q[g] <= ~bclk_q[g];
        end else begin
          cnt_q <= cnt_q + 12'h001;
        end
      end
    end
  endgenerate

  // Own UART 16x ticks; a fitted option may supply its own clocks
  wire tx_edge = pin_q[`PIN_OWN_TX_CLK] & ~pin_prev_q[`PIN_OWN_TX_CLK];
  wire rx_edge = pin_q[`PIN_OWN_RX_CLK] & ~pin_prev_q[`PIN_OWN_RX_CLK];
  wire tx_tick = fitted ? tx_edge : brise[0];
  wire rx_tick = fitted ? rx_edge : brise[1];

  wire [3:0] frame_len = 4'h9 + {3'h0, ~n7} + {3'h0, par_en};

  function [10:0] frame;
    input [7:0] d;
    input f7;
    input fpar;
    input fodd;
    reg pb;
    reg [7:0] ext;
    begin
      pb = (^(f7 ? {1'b0, d[6:0]} : d)) ^ fodd;
      ext = f7 ? {fpar ? pb : 1'b1, d[6:0]} : d;
      frame = {1'b1, (fpar & ~f7) ? pb : 1'b1, ext, 1'b0};
    end
  endfunction

  // Receive buffer: head and skid register, so a stalled reader loses no word until both are full; a third word is dropped and flags rx_error_o
  reg [7:0] head_q, skid_q;
  reg head_v_q, skid_v_q, rx_err_q;
  reg push;
  reg [7:0] push_data;
  wire pop = head_v_q & rx_ready_i;

  // Flow control state
  reg stopped_q, xoff_sent_q;
  wire want_xoff = fitted & head_v_q & ~rx_ready_i & ~xoff_sent_q;
  wire want_xon = xoff_sent_q & ~head_v_q;

  // Transmitter
  reg [10:0] tx_sh_q;
  reg [3:0] tx_ph_q, tx_left_q;
  reg tx_busy_q, hold_v_q, tx_ready_q;
  reg [7:0] hold_q;
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      tx_sh_q <= `FRAME_IDLE;
      tx_ph_q <= 4'h0;
      tx_left_q <= 4'h0;
      tx_busy_q <= 1'b0;
      hold_v_q <= 1'b0;
      hold_q <= 8'h00;
      tx_ready_q <= 1'b1;
      xoff_sent_q <= 1'b0;
    end else begin
      if (~fitted) begin
        xoff_sent_q <= 1'b0;
      end
      if (tx_valid_i & tx_ready_q) begin
        hold_q <= tx_data_i;
        hold_v_q <= 1'b1;
        tx_ready_q <= 1'b0;
      end
      if (tx_tick & tx_busy_q) begin
        tx_ph_q <= tx_ph_q + 4'h1;
        if (tx_ph_q == 4'hf) begin
          tx_sh_q <= {1'b1, tx_sh_q[10:1]};
          tx_left_q <= tx_left_q - 4'h1;
          if (tx_left_q == 4'h1) begin
            tx_busy_q <= 1'b0;
          end
        end
      end else if (tx_tick) begin
        tx_ph_q <= 4'h0;
        tx_left_q <= frame_len;
        if (want_xoff) begin
          tx_sh_q <= frame(`XOFF_CHAR, 1'b0, 1'b0, 1'b0);
          tx_busy_q <= 1'b1;
          xoff_sent_q <= 1'b1;
        end else if (want_xon) begin
          tx_sh_q <= frame(`XON_CHAR, 1'b0, 1'b0, 1'b0);
          tx_busy_q <= 1'b1;
          xoff_sent_q <= 1'b0;
        end else if (hold_v_q & ~stopped_q) begin
          tx_sh_q <= frame(hold_q, n7, par_en, parity_odd_i);
          tx_busy_q <= 1'b1;
          hold_v_q <= 1'b0;
          tx_ready_q <= 1'b1;
        end
      end
    end
  end

  // Receiver
  reg [9:0] rx_bits_q;
  reg [3:0] rx_ph_q, rx_idx_q;
  reg rx_busy_q, rx_start_q, rx_done_q;
  wire [7:0] rx_word = n7 ? {1'b0, rx_bits_q[6:0]} : rx_bits_q[7:0];
  wire rx_pb = n7 ? rx_bits_q[7] : rx_bits_q[8];
  wire rx_bad = ~rx_bits_q[frame_len - 4'h2] | (par_en & ((^rx_word) ^ rx_pb ^ parity_odd_i));
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rx_bits_q <= 10'h000;
      rx_ph_q <= 4'h0;
      rx_idx_q <= 4'h0;
      rx_busy_q <= 1'b0;
      rx_start_q <= 1'b0;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (rx_tick & ~rx_busy_q & ~rxd) begin
        rx_busy_q <= 1'b1;
        rx_start_q <= 1'b1;
        rx_ph_q <= 4'h0;
        rx_idx_q <= 4'h0;
      end else if (rx_tick & rx_busy_q) begin
        rx_ph_q <= rx_ph_q + 4'h1;
        if (rx_start_q & (rx_ph_q == 4'h7)) begin
          // Mid-start check rejects glitches shorter than half a bit
          rx_start_q <= 1'b0;
          rx_ph_q <= 4'h0;
          rx_busy_q <= ~rxd;
        end else if (~rx_start_q & (rx_ph_q == 4'hf)) begin
          rx_bits_q[rx_idx_q] <= rxd;
          rx_idx_q <= rx_idx_q + 4'h1;
          if (rx_idx_q == frame_len - 4'h2) begin
            rx_busy_q <= 1'b0;
            rx_done_q <= 1'b1;
          end
        end
      end
    end
  end

  // Received XON/XOFF are consumed on the fitted link, not delivered
  always @* begin
    push = rx_done_q & ~rx_bad;
    push_data = rx_word;
    if (fitted & ((rx_word == `XON_CHAR) | (rx_word == `XOFF_CHAR))) begin
      push = 1'b0;
    end
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      stopped_q <= 1'b0;
      head_q <= 8'h00;
      skid_q <= 8'h00;
      head_v_q <= 1'b0;
      skid_v_q <= 1'b0;
      rx_err_q <= 1'b0;
    end else begin
      if (~fitted) begin
        stopped_q <= 1'b0;
      end else if (rx_done_q & ~rx_bad & (rx_word == `XOFF_CHAR)) begin
        stopped_q <= 1'b1;
      end else if (rx_done_q & ~rx_bad & (rx_word == `XON_CHAR)) begin
        stopped_q <= 1'b0;
      end
      rx_err_q <= (rx_done_q & rx_bad) | (push & ~pop & skid_v_q);
      if (pop) begin
        if (skid_v_q) begin
          head_q <= skid_q;
          skid_v_q <= push;
          skid_q <= push_data;
        end else begin
          head_v_q <= push;
          head_q <= push_data;
        end
      end else if (push) begin
        if (~head_v_q) begin
          head_v_q <= 1'b1;
          head_q <= push_data;
        end else if (~skid_v_q) begin
          skid_v_q <= 1'b1;
          skid_q <= push_data;
        end
      end
    end
  end

  // Reset notice and modem control outputs
  reg [`NOTICE_W-1:0] notice_cnt_q;
  reg notice_q, rts_q, dtr_q, srq_q;
  always @(posedge sys_clk_i) begin
    if (sys_rst_i | terminal_reset_i) begin
      notice_cnt_q <= NOTICE_LEN[`NOTICE_W-1:0];
      notice_q <= 1'b1;
    end else begin
      if (notice_cnt_q != {`NOTICE_W{1'b0}}) begin
        notice_cnt_q <= notice_cnt_q - {{(`NOTICE_W-1){1'b0}}, 1'b1};
      end
      notice_q <= (notice_cnt_q > {{(`NOTICE_W-1){1'b0}}, 1'b1});
    end
  end
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rts_q <= 1'b0;
      dtr_q <= 1'b0;
      srq_q <= 1'b0;
    end else begin
      rts_q <= req_to_send_i;
      dtr_q <= term_ready_i;
      srq_q <= secondary_req_i;
    end
  end

  assign tx_ready_o = tx_ready_q;
  assign rx_data_o = head_q;
  assign rx_valid_o = head_v_q;
  assign rx_error_o = rx_err_q;
  assign tx_stopped_o = stopped_q;
  assign ctl_serial_out_o = tx_sh_q[0];
  assign ctl_tx_baud_clk_o = bclk_q[0];
  assign ctl_rx_baud_clk_o = bclk_q[1];
  assign local_link_clk_o = bclk_q[2];
  assign controller_reset_notice_o = notice_q;
  assign ctl_request_to_send_o = rts_q;
  assign ctl_terminal_ready_o = dtr_q;
  assign ctl_secondary_request_o = srq_q;
  assign option_fitted_o = fitted;
  assign set_ready_o = pin_q[`PIN_SET_READY];
  assign clear_to_send_o = pin_q[`PIN_CLEAR_TO_SEND];
  assign carrier_o = pin_q[`PIN_CARRIER];
  assign ctl_secondary_carrier_o = pin_q[`PIN_SEC_CARRIER];
  assign ring_o = pin_q[`PIN_RING];

endmodule // splice_port

// ===== core/splice_port_defines.vh
`ifndef SPLICE_PORT_DEFINES_VH
`define SPLICE_PORT_DEFINES_VH

// Clocking
`define SYS_CLK_HZ 25000000
`define SYS_CLK_NS 40
`define OVERSAMPLE 16
`define LOCAL_CLK_HZ 251744
`define LOCAL_HALF_CYC (`SYS_CLK_HZ / (2 * `LOCAL_CLK_HZ))
`define DIV_W 12

// Reset notice pulse: least time, rounded up
`define NOTICE_NS 10000
`define NOTICE_CYC ((`NOTICE_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define NOTICE_W 9

// Flow-control characters
`define XON_CHAR 8'h11
`define XOFF_CHAR 8'h13

// Pin synchroniser slots
`define PIN_N 9
`define PIN_PRESENT 0
`define PIN_SERIAL_IN 1
`define PIN_OWN_TX_CLK 2
`define PIN_OWN_RX_CLK 3
`define PIN_SET_READY 4
`define PIN_CLEAR_TO_SEND 5
`define PIN_CARRIER 6
`define PIN_SEC_CARRIER 7
`define PIN_RING 8

// Reset values
`define PIN_IDLE 9'h0002
`define FRAME_IDLE 11'h07ff

`endif

// ===== tb/option_card_model.sv
`timescale 1ns/1ps
module option_card_model (
  input wire serial_i,
  output logic present_o,
  output logic serial_o,
  output logic uart_clk_o,
  output logic [4:0] status_o
);
  localparam realtime BIT_NS = 5120.0;
  logic [7:0] got_q[$];
  logic [7:0] shift_q;
  initial begin
    present_o = 1'b0;
    serial_o = 1'b1;
    status_o = 5'h15;
    uart_clk_o = 1'b0;
    // One 16x clock feeds both own UART clocks
    forever #160 uart_clk_o = ~uart_clk_o;
  end
  // Ignores any XOFF: only the buffer test calls it while stopped
  task automatic send(input logic [7:0] b);
    serial_o = 1'b0;
    #BIT_NS;
    for (int i = 0; i < 8; i++) begin
      serial_o = b[i];
      #BIT_NS;
    end
    serial_o = 1'b1;
    #BIT_NS;
  endtask
  // Bad stop bit drops the frame, so a wrong length shows as a loss only if a 0 falls in the stop slot
  always begin
    @(negedge serial_i);
    #(BIT_NS * 1.5);
    for (int i = 0; i < 8; i++) begin
      shift_q[i] = serial_i;
      #BIT_NS;
    end
    if (serial_i === 1'b1) got_q.push_back(shift_q);
  end
endmodule // option_card_model

// ===== tb/splice_port_props.sv
`timescale 1ns/1ps
`include "splice_port_defines.vh"
module splice_port_props (
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire option_present_i,
  input wire option_fitted_o,
  input wire [`DIV_W-1:0] tx_half_div_i,
  input wire [`DIV_W-1:0] rx_half_div_i,
  input wire ctl_tx_baud_clk_o,
  input wire ctl_rx_baud_clk_o,
  input wire terminal_reset_i,
  input wire controller_reset_notice_o,
  input wire req_to_send_i,
  input wire term_ready_i,
  input wire ctl_request_to_send_o,
  input wire ctl_terminal_ready_o,
  input wire tx_valid_i,
  input wire tx_ready_o,
  input wire rx_valid_o,
  input wire rx_ready_i,
  input wire [7:0] rx_data_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Period checks only armed for a half divisor of 4
  property p_tx_baud;
    $changed(ctl_tx_baud_clk_o) && tx_half_div_i == 12'h004
      |=> $stable(ctl_tx_baud_clk_o) [*3] ##1 $changed(ctl_tx_baud_clk_o);
  endproperty
  property p_rx_baud;
    $changed(ctl_rx_baud_clk_o) && rx_half_div_i == 12'h004
      |=> $stable(ctl_rx_baud_clk_o) [*3] ##1 $changed(ctl_rx_baud_clk_o);
  endproperty
  property p_sync_wait;
    $rose(option_present_i) |-> !option_fitted_o ##1 !option_fitted_o;
  endproperty
  property p_fitted; option_present_i [*6] |-> option_fitted_o; endproperty
  property p_notice; $fell(terminal_reset_i) |=> controller_reset_notice_o [*8]; endproperty
  property p_modem;
    $changed(req_to_send_i) || $changed(term_ready_i) |=> ctl_request_to_send_o ==
      $past(req_to_send_i) && ctl_terminal_ready_o == $past(term_ready_i);
  endproperty
  property p_tx_take; tx_valid_i && tx_ready_o |=> !tx_ready_o; endproperty
  property p_hold; rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o); endproperty
  a_tx_baud: assert property (p_tx_baud) else $error("tx baud clock period");
  a_rx_baud: assert property (p_rx_baud) else $error("rx baud clock period");
  a_sync_wait: assert property (p_sync_wait) else $error("presence unsynchronised");
  a_fitted: assert property (p_fitted) else $error("presence not followed");
  a_notice: assert property (p_notice) else $error("reset notice short");
  a_modem: assert property (p_modem) else $error("modem control not forwarded");
  a_tx_take: assert property (p_tx_take) else $error("tx ready after take");
  a_hold: assert property (p_hold) else $error("rx word not held");
  c_fitted: cover property ($rose(option_fitted_o));
  c_stall: cover property (rx_valid_o && !rx_ready_i);
  c_take: cover property (tx_valid_i && tx_ready_o);
endmodule // splice_port_props
bind splice_port splice_port_props props_u (.*);

// ===== tb/terminal_option_splice_port_tb.sv
`timescale 1ns/1ps
`include "splice_port_defines.vh"
module terminal_option_splice_port_tb;
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, char_7bit_i = 1'b0, parity_en_i = 1'b0;
  logic parity_odd_i = 1'b0, terminal_reset_i = 1'b0, req_to_send_i = 1'b0;
  logic term_ready_i = 1'b0, secondary_req_i = 1'b0, tx_valid_i = 1'b0, rx_ready_i = 1'b1;
  logic err_seen = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic [`DIV_W-1:0] tx_half_div_i = 12'h004, rx_half_div_i = 12'h004;
  wire option_present_i, ctl_serial_in_i, own_uart_tx_clk_i, own_uart_rx_clk_i;
  wire set_ready_i, clear_to_send_i, carrier_i, ctl_secondary_carrier_i, ring_i;
  wire tx_ready_o, rx_valid_o, rx_error_o, tx_stopped_o, ctl_serial_out_o, option_fitted_o;
  wire ctl_tx_baud_clk_o, ctl_rx_baud_clk_o, local_link_clk_o, controller_reset_notice_o;
  wire ctl_request_to_send_o, ctl_terminal_ready_o, ctl_secondary_request_o;
  wire set_ready_o, clear_to_send_o, carrier_o, ctl_secondary_carrier_o, ring_o;
  wire [7:0] rx_data_o;
  wire [4:0] status_seen = {set_ready_o, clear_to_send_o, carrier_o,
    ctl_secondary_carrier_o, ring_o};
  wire [2:0] modem_seen = {ctl_request_to_send_o, ctl_terminal_ready_o, ctl_secondary_request_o};
  int errors = 0, total_checks = 0, n = 0;
  assign own_uart_rx_clk_i = own_uart_tx_clk_i;
  splice_port dut_u (.*);
  option_card_model opt_u (
    .serial_i(ctl_serial_out_o),
    .present_o(option_present_i),
    .serial_o(ctl_serial_in_i),
    .uart_clk_o(own_uart_tx_clk_i),
    .status_o({set_ready_i, clear_to_send_i, carrier_i, ctl_secondary_carrier_i, ring_i})
  );
  initial forever #20 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (rx_error_o === 1'b1) err_seen <= 1'b1;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic bound(input logic ok);
    if (!ok) begin
      errors++;
      summarize();
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk_i);
  endtask
  task automatic got(input logic [7:0] exp);
    for (n = 0; opt_u.got_q.size() == 0 && n < 3000; n++) cyc(1);
    bound(opt_u.got_q.size() > 0);
    check(opt_u.got_q.pop_front(), exp);
  endtask
  task automatic put(input logic [7:0] b);
    for (n = 0; tx_ready_o !== 1'b1 && n < 3000; n++) cyc(1);
    bound(tx_ready_o === 1'b1);
    tx_data_i = b;
    tx_valid_i = 1'b1;
    cyc(1);
    tx_valid_i = 1'b0;
  endtask
  task automatic take(input logic [7:0] exp);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (rx_valid_o !== 1'b1 && n < 3000);
    bound(rx_valid_o === 1'b1);
    check(rx_data_o, exp);
  endtask
  task automatic notice_len();
    for (n = 0; controller_reset_notice_o === 1'b1 && n < 400; n++) cyc(1);
    check(n >= 248 && n <= 252, 1'b1);
  endtask
  task automatic lvl(input logic v);
    for (; local_link_clk_o !== v && n < 300; n++) @(posedge sys_clk_i) #1;
  endtask
  task automatic t_reset();
    cyc(6);
    check({controller_reset_notice_o, ctl_serial_out_o, tx_ready_o, rx_valid_o}, 8'h0e);
    sys_rst_i = 1'b0;
    notice_len();
    n = 0;
    lvl(1'b0);
    lvl(1'b1);
    n = 0;
    lvl(1'b0);
    lvl(1'b1);
    check(n[7:0], 8'h62);
    cyc(1);
    $display("reset test done");
  endtask
  task automatic t_plain();
    put(8'ha5);
    got(8'ha5);
    char_7bit_i = 1'b1;
    parity_en_i = 1'b1;
    put(8'h31);
    got(8'hb1);
    parity_odd_i = 1'b1;
    put(8'h31);
    got(8'h31);
    char_7bit_i = 1'b0;
    put(8'ha5);
    got(8'ha5);
    char_7bit_i = 1'b1;
    rx_ready_i = 1'b0;
    opt_u.send(8'h4a);
    take(8'h4a);
    rx_ready_i = 1'b1;
    cyc(1);
    terminal_reset_i = 1'b1;
    cyc(3);
    terminal_reset_i = 1'b0;
    notice_len();
    {req_to_send_i, term_ready_i, secondary_req_i} = 3'h7;
    cyc(2);
    check(modem_seen, 8'h07);
    check(status_seen, 8'h15);
    opt_u.status_o = 5'h0a;
    {req_to_send_i, term_ready_i, secondary_req_i} = 3'h2;
    cyc(5);
    check(status_seen, 8'h0a);
    check(modem_seen, 8'h02);
    check(option_fitted_o, 1'b0);
    $display("unfitted test done");
  endtask
  task automatic t_fitted();
    opt_u.present_o = 1'b1;
    cyc(6);
    check(option_fitted_o, 1'b1);
    put(8'h31);
    got(8'h31);
    rx_ready_i = 1'b0;
    opt_u.send(8'h13);
    cyc(4);
    check({tx_stopped_o, rx_valid_o}, 8'h02);
    put(8'h66);
    cyc(1600);
    check(opt_u.got_q.size() == 0, 1'b1);
    opt_u.send(8'h11);
    got(8'h66);
    check({tx_stopped_o, rx_valid_o}, 8'h00);
    $display("fitted flow test done");
  endtask
  task automatic t_buffer();
    opt_u.send(8'hc3);
    got(8'h13);
    opt_u.send(8'h02);
    opt_u.send(8'h03);
    cyc(4);
    check(err_seen, 1'b1);
    take(8'hc3);
    rx_ready_i = 1'b1;
    take(8'h02);
    got(8'h11);
    check(rx_valid_o, 1'b0);
    $display("buffer test done");
  endtask
  initial begin
    t_reset();
    t_plain();
    t_fitted();
    t_buffer();
    summarize();
  end
endmodule // terminal_option_splice_port_tb
